// File: srh_bus_model.sv
/*
 * Traced bus stand-in: loops one opcode fetch at 10h and accesses at 80h, 81h, 82h.
 * Assumes a six-clock state period; data settles three clocks before each strobe rise.
 */
`timescale 1ns/100ps
module srh_bus_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        en_i,
	output logic             state_clk_o,
	output logic             opcode_fetch_o,
	output logic      [31:0] probe_data_o
);
	logic [2:0] phase_reg;
	logic [1:0] idx_reg;
	logic [1:0] idx_next;
	logic [7:0] val;
	assign idx_next = idx_reg + 2'h1;
	assign val = (idx_next == 2'h0) ? 8'h10 : 8'h7F + {6'h00, idx_next};
	initial begin
		phase_reg = 3'h0;
		idx_reg = 2'h3;
		state_clk_o = 1'b0;
		opcode_fetch_o = 1'b0;
		probe_data_o = 32'h0;
	end
	always @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			// Out of frame: strobe parked, data keeps moving so nothing stale looks valid
			phase_reg      <= 3'h0;
			state_clk_o    <= 1'b0;
			opcode_fetch_o <= ~opcode_fetch_o;
			probe_data_o   <= ~probe_data_o;
		end else begin
			phase_reg   <= (phase_reg == 3'h5) ? 3'h0 : phase_reg + 3'h1;
			state_clk_o <= phase_reg == 3'h3 || phase_reg == 3'h4;
			if (phase_reg == 3'h0) begin
				idx_reg        <= idx_next;
				opcode_fetch_o <= idx_next == 2'h0;
				probe_data_o   <= {16'h0, val, ~val};
			end
		end
	end
endmodule : srh_bus_model

// File: srh_engine.sv
/*
 * State range histogram engine: samples qualified states of a traced bus in
 * blocks of 1024 with random gaps, sorts them into eight ranges of one label,
 * and reports totals and percentages over a classic Wishbone slave.
 * Assumes the traced bus strobe, status and data arrive asynchronously and are
 * held stable for at least three clocks around each strobe rising edge.
 */
`timescale 1ns/100ps
`include "srh_regs.svh"
module srh_engine (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [7:0]   wb_adr_i,
	input  wire logic [31:0]  wb_dat_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic         wb_we_i,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	output srh_pkg::srh_word_type wb_dat_o,
	output logic              wb_ack_o,
	input  wire logic         state_clk_i,
	input  wire logic         opcode_fetch_i,
	input  wire logic [31:0]  probe_data_i,
	output logic              running_o
);
	import srh_pkg::*;

	// Pin synchronisers
	logic [31:0]   data_meta_reg;
	logic [31:0]   data_sync_reg;
	logic          op_meta_reg;
	logic          op_sync_reg;
	logic          sclk_meta_reg;
	logic          sclk_sync_reg;
	logic          sclk_prev_reg;
	logic          state_edge;

	// Configuration
	logic          mode_prog_reg;
	logic          incl_inrange_reg;
	srh_index_type label_sel_reg;
	logic [7:0]    range_en_reg;
	logic [4:0]    shift_reg [8];
	srh_word_type  mask_reg  [8];
	srh_word_type  min_reg   [8];
	srh_word_type  max_reg   [8];

	// Measurement
	srh_state_type st_reg;
	logic [7:0]    gap_reg;
	logic [9:0]    smp_cnt_reg;
	logic          stop_pend_reg;
	logic          aborted_reg;
	logic          done_reg;
	srh_word_type  total_reg;
	srh_word_type  inrange_reg;
	logic [10:0]   smp_in_reg;
	logic [10:0]   smp_hit_reg [8];
	srh_word_type  hit_reg     [8];
	logic [7:0]    op_vec_reg;
	logic [6:0]    pct_reg     [8];
	srh_index_type pct_idx_reg;

	logic          ack_reg;
	logic [15:0]   rnd;
	srh_word_type  label_val;
	logic [7:0]    in_vec;
	logic [7:0]    credit;
	logic          any_hit;
	logic          wr_en;
	logic          start_p;
	logic          stop_p;
	logic          clear_all;
	logic          abort_now;
	logic          count_en;
	logic          commit;
	logic [2:0]    bank;
	srh_index_type widx;
	srh_word_type  rd_data;
	logic          div_busy;
	logic          div_done;
	logic [6:0]    div_q;
	logic [39:0]   div_num;
	srh_word_type  div_den;

	function automatic srh_word_type merge(input srh_word_type old_v, input srh_word_type new_v,
		input logic [3:0] be);
		srh_word_type r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	srh_lfsr u_lfsr (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.rnd_o (rnd)
	);

	// Second stage feeds logic; third stage only for edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_meta_reg <= 32'h00000000;
			data_sync_reg <= 32'h00000000;
			op_meta_reg   <= 1'b0;
			op_sync_reg   <= 1'b0;
			sclk_meta_reg <= 1'b0;
			sclk_sync_reg <= 1'b0;
			sclk_prev_reg <= 1'b0;
		end else if (ce_i) begin
			data_meta_reg <= probe_data_i;
			data_sync_reg <= data_meta_reg;
			op_meta_reg   <= opcode_fetch_i;
			op_sync_reg   <= op_meta_reg;
			sclk_meta_reg <= state_clk_i;
			sclk_sync_reg <= sclk_meta_reg;
			sclk_prev_reg <= sclk_sync_reg;
		end
	end

	assign state_edge = sclk_sync_reg && !sclk_prev_reg;

	// Label extraction and range compare
	assign label_val = (data_sync_reg >> shift_reg[label_sel_reg]) & mask_reg[label_sel_reg]; // [RULE_06]

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_range
			assign in_vec[gi] = range_en_reg[gi] && (label_val >= min_reg[gi])
				&& (label_val <= max_reg[gi]); // [RULE_07] [RULE_13]
		end
	endgenerate

	// Accesses after an opcode fetch inherit that fetch's ranges in program mode
	assign credit  = (mode_prog_reg && !op_sync_reg) ? op_vec_reg : in_vec; // [RULE_08] [RULE_09]
	assign any_hit = |credit;

	// Bus decode
	assign wr_en     = ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
	assign bank      = wb_adr_i[7:5];
	assign widx      = wb_adr_i[4:2];
	assign start_p   = wr_en && wb_sel_i[0] && (wb_adr_i == `SRH_ADR_CTRL) && wb_dat_i[`SRH_CTRL_START];
	assign stop_p    = wr_en && wb_sel_i[0] && (wb_adr_i == `SRH_ADR_CTRL) && wb_dat_i[`SRH_CTRL_STOP];
	assign clear_all = start_p;
	assign abort_now = stop_p && stop_pend_reg && (st_reg != SRH_IDLE) && !start_p; // [RULE_05]
	assign count_en  = ce_i && (st_reg == SRH_SAMPLE) && state_edge && !abort_now && !start_p;
	assign commit    = count_en && (smp_cnt_reg == `SRH_SAMPLE_LAST); // [RULE_01]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg  <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (ce_i) begin
			ack_reg  <= wb_cyc_i && wb_stb_i && !ack_reg;
			wb_ack_o <= wb_cyc_i && wb_stb_i && !ack_reg;
			wb_dat_o <= rd_data;
		end
	end

	always_comb begin
		rd_data = 32'h00000000;
		case (bank)
			`SRH_BANK_MISC: begin
				case (wb_adr_i)
					`SRH_ADR_CTRL: begin
						rd_data[`SRH_CTRL_MODE]                     = mode_prog_reg;
						rd_data[`SRH_CTRL_INCL]                     = incl_inrange_reg;
						rd_data[`SRH_CTRL_LBL_HI:`SRH_CTRL_LBL_LO] = label_sel_reg;
					end
					`SRH_ADR_STATUS: begin
						rd_data[`SRH_STAT_RUN]      = (st_reg != SRH_IDLE);
						rd_data[`SRH_STAT_STOPPING] = stop_pend_reg;
						rd_data[`SRH_STAT_ABORTED]  = aborted_reg;
						rd_data[`SRH_STAT_DONE]     = done_reg;
					end
					`SRH_ADR_TOTAL:    rd_data = total_reg; // [RULE_10]
					`SRH_ADR_INRANGE:  rd_data = inrange_reg;
					`SRH_ADR_RANGE_EN: rd_data[7:0] = range_en_reg;
					default:           rd_data = 32'h00000000;
				endcase
			end
			`SRH_BANK_SHIFT: rd_data[4:0] = shift_reg[widx];
			`SRH_BANK_MASK:  rd_data = mask_reg[widx];
			`SRH_BANK_MIN:   rd_data = min_reg[widx];
			`SRH_BANK_MAX:   rd_data = max_reg[widx];
			`SRH_BANK_HITS:  rd_data = hit_reg[widx];
			`SRH_BANK_PCT:   rd_data[6:0] = pct_reg[widx]; // [RULE_12]
			default:         rd_data = 32'h00000000;
		endcase
	end

	// Configuration writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_prog_reg    <= 1'b0;
			incl_inrange_reg <= 1'b0;
			label_sel_reg    <= 3'h0;
			range_en_reg     <= `SRH_RST_RANGE_EN;
		end else if (wr_en && (bank == `SRH_BANK_MISC)) begin
			if (wb_adr_i == `SRH_ADR_CTRL && wb_sel_i[0]) begin
				mode_prog_reg    <= wb_dat_i[`SRH_CTRL_MODE];
				incl_inrange_reg <= wb_dat_i[`SRH_CTRL_INCL]; // [RULE_11]
				label_sel_reg    <= wb_dat_i[`SRH_CTRL_LBL_HI:`SRH_CTRL_LBL_LO];
			end
			if (wb_adr_i == `SRH_ADR_RANGE_EN && wb_sel_i[0]) begin
				range_en_reg <= wb_dat_i[7:0];
			end
		end
	end

	// Per-range configuration, sample and total counters
	generate
		for (gi = 0; gi < 8; gi++) begin : g_cnt
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					shift_reg[gi] <= 5'h00;
					mask_reg[gi]  <= `SRH_RST_MASK;
					min_reg[gi]   <= 32'h00000000;
					max_reg[gi]   <= 32'h00000000;
				end else if (wr_en && (widx == gi)) begin
					if (bank == `SRH_BANK_SHIFT && wb_sel_i[0]) begin
						shift_reg[gi] <= wb_dat_i[4:0];
					end
					if (bank == `SRH_BANK_MASK) begin
						mask_reg[gi] <= merge(mask_reg[gi], wb_dat_i, wb_sel_i);
					end
					if (bank == `SRH_BANK_MIN) begin
						min_reg[gi] <= merge(min_reg[gi], wb_dat_i, wb_sel_i);
					end
					if (bank == `SRH_BANK_MAX) begin
						max_reg[gi] <= merge(max_reg[gi], wb_dat_i, wb_sel_i);
					end
				end
			end

			// Sample counts are held apart so an abort can drop them whole
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					smp_hit_reg[gi] <= 11'h000;
					hit_reg[gi]     <= 32'h00000000;
				end else if (ce_i) begin
					if (clear_all) begin
						smp_hit_reg[gi] <= 11'h000;
						hit_reg[gi]     <= 32'h00000000;
					end else if (abort_now) begin
						smp_hit_reg[gi] <= 11'h000; // [RULE_05]
					end else if (commit) begin
						smp_hit_reg[gi] <= 11'h000;
						hit_reg[gi]     <= hit_reg[gi] + {21'h000000, smp_hit_reg[gi]}
							+ {31'h00000000, credit[gi]}; // [RULE_01]
					end else if (count_en && credit[gi]) begin
						smp_hit_reg[gi] <= smp_hit_reg[gi] + 11'h001;
					end
				end
			end
		end
	endgenerate

	// Range context of the last opcode fetch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_vec_reg <= 8'h00;
		end else if (ce_i && state_edge && op_sync_reg) begin
			op_vec_reg <= in_vec; // [RULE_09]
		end
	end

	// Sample sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg        <= SRH_IDLE;
			gap_reg       <= 8'h00;
			smp_cnt_reg   <= 10'h000;
			stop_pend_reg <= 1'b0;
			aborted_reg   <= 1'b0;
			done_reg      <= 1'b0;
			running_o     <= 1'b0;
		end else if (ce_i) begin
			running_o <= 1'b0;
			if (start_p) begin
				st_reg        <= SRH_GAP;
				gap_reg       <= rnd[7:0]; // [RULE_02]
				smp_cnt_reg   <= 10'h000;
				stop_pend_reg <= 1'b0;
				aborted_reg   <= 1'b0;
				done_reg      <= 1'b0;
				running_o     <= 1'b1;
			end else if (abort_now) begin
				st_reg        <= SRH_IDLE; // [RULE_05]
				smp_cnt_reg   <= 10'h000;
				stop_pend_reg <= 1'b0;
				aborted_reg   <= 1'b1;
			end else begin
				running_o <= (st_reg != SRH_IDLE);
				if (stop_p && st_reg != SRH_IDLE) begin
					stop_pend_reg <= 1'b1; // [RULE_04]
				end
				case (st_reg)
					SRH_IDLE: begin
						st_reg <= SRH_IDLE;
					end
					SRH_GAP: begin
						if (gap_reg == 8'h00) begin
							st_reg <= SRH_SAMPLE;
						end else begin
							gap_reg <= gap_reg - 8'h01;
						end
					end
					SRH_SAMPLE: begin
						if (commit) begin
							smp_cnt_reg <= 10'h000;
							if (stop_pend_reg || stop_p) begin
								st_reg        <= SRH_IDLE; // [RULE_04]
								stop_pend_reg <= 1'b0;
								done_reg      <= 1'b1;
								running_o     <= 1'b0;
							end else begin
								st_reg  <= SRH_GAP; // [RULE_03]
								gap_reg <= rnd[7:0]; // [RULE_02]
							end
						end else if (count_en) begin
							smp_cnt_reg <= smp_cnt_reg + 10'h001;
						end
					end
					default: begin
						st_reg <= SRH_IDLE;
					end
				endcase
			end
		end
	end

	// Totals over committed samples
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			total_reg   <= 32'h00000000;
			inrange_reg <= 32'h00000000;
			smp_in_reg  <= 11'h000;
		end else if (ce_i) begin
			if (clear_all || abort_now) begin
				smp_in_reg <= 11'h000;
				if (clear_all) begin
					total_reg   <= 32'h00000000;
					inrange_reg <= 32'h00000000;
				end
			end else if (commit) begin
				smp_in_reg  <= 11'h000;
				total_reg   <= total_reg + `SRH_SAMPLE_STATES; // [RULE_10]
				inrange_reg <= inrange_reg + {21'h000000, smp_in_reg} + {31'h00000000, any_hit};
			end else if (count_en && any_hit) begin
				smp_in_reg <= smp_in_reg + 11'h001;
			end
		end
	end

	// Percentages refreshed round robin, one range per division
	assign div_den = incl_inrange_reg ? inrange_reg : total_reg; // [RULE_11]
	assign div_num = {8'h00, hit_reg[pct_idx_reg]} * `SRH_PCT_SCALE;

	srh_pct_div u_div (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.start_i    (!div_busy && !div_done),
		.dividend_i (div_num),
		.divisor_i  (div_den),
		.busy_o     (div_busy),
		.done_o     (div_done),
		.quot_o     (div_q)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pct_idx_reg <= 3'h0;
			for (int i = 0; i < 8; i++) begin
				pct_reg[i] <= 7'h00;
			end
		end else if (ce_i && div_done) begin
			pct_reg[pct_idx_reg] <= div_q; // [RULE_12]
			pct_idx_reg          <= pct_idx_reg + 3'h1;
		end
	end
endmodule : srh_engine

// File: srh_engine_properties.sv
/*
 * Concurrent checks on the histogram engine's bus handshake and run/stop behaviour.
 * Assumes binding onto srh_engine, one clock, synchronous active-high reset.
 */
`timescale 1ns/100ps
`include "srh_regs.svh"
module srh_engine_properties (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [31:0]           wb_dat_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic                  wb_we_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire srh_pkg::srh_word_type wb_dat_o,
	input  wire logic                  wb_ack_o,
	input  wire logic                  running_o
);
	import srh_pkg::*;
	logic        req;
	logic        start_wr;
	logic        stop_wr;
	logic        unmapped;
	logic        stop_reg;
	logic        abort_reg;
	logic [15:0] run_cnt_reg;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	assign start_wr = req && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0] && wb_dat_i[0];
	assign stop_wr = req && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0] && wb_dat_i[1] && !wb_dat_i[0];
	assign unmapped = wb_adr_i[7:5] == 3'h3 || (wb_adr_i[7:5] == `SRH_BANK_MISC && wb_adr_i[4:2] > 3'h4);
	// Cleared one edge late on purpose: a falling run still sees why it stopped
	always_ff @(posedge clk_i) begin
		if (rst_i || start_wr || !running_o) begin
			stop_reg  <= 1'b0;
			abort_reg <= 1'b0;
		end else if (stop_wr) begin
			stop_reg  <= 1'b1;
			abort_reg <= stop_reg;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || start_wr || !running_o)
			run_cnt_reg <= 16'h0000;
		else if (run_cnt_reg != 16'hFFFF)
			run_cnt_reg <= run_cnt_reg + 16'h0001;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_follows: assert property (req |=> wb_ack_o) else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !running_o && wb_dat_o == 32'h0)
		else $error("outputs active in reset");
	a_unmapped_zero: assert property (req && !wb_we_i && unmapped |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_start_runs: assert property (start_wr |-> ##[1:2] running_o) else $error("start ignored");
	a_stays_running: assert property ($fell(running_o) |-> stop_reg) else $error("run ended unasked");
	a_last_sample: assert property ($fell(running_o) && !abort_reg |-> run_cnt_reg >= 16'h0FFC)
		else $error("run ended before a full sample");
	a_abort_quick: assert property (stop_wr && stop_reg && running_o |-> ##[1:4] !running_o)
		else $error("second stop did not abort");
	a_stop_idle: assert property (stop_wr && !running_o |=> !running_o [*2]) else $error("idle stop started");
	c_abort: cover property ($fell(running_o) && abort_reg);
	c_graceful: cover property ($fell(running_o) && !abort_reg);
	c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : srh_engine_properties

bind srh_engine srh_engine_properties srh_engine_properties_i (.clk_i, .rst_i, .ce_i, .wb_adr_i, .wb_dat_i,
	.wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .running_o);

// File: srh_lfsr.sv
/*
 * Free-running 16-bit Galois LFSR giving the random gap between samples.
 * Assumes one clock, synchronous active-high reset and a clock enable.
 */
`timescale 1ns/100ps
`include "srh_regs.svh"
module srh_lfsr (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	output logic      [15:0] rnd_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rnd_o <= `SRH_LFSR_SEED;
		end else if (ce_i) begin
			rnd_o <= rnd_o[0] ? ((rnd_o >> 1) ^ `SRH_LFSR_TAPS) : (rnd_o >> 1);
		end
	end
endmodule : srh_lfsr

// File: srh_pct_div.sv
/*
 * Sequential divider giving hits*100/denominator as a 7-bit percentage.
 * Assumes dividend never exceeds 100 times the divisor; a zero divisor yields 0.
 */
`timescale 1ns/100ps
`include "srh_regs.svh"
module srh_pct_div (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        start_i,
	input  wire logic [39:0] dividend_i,
	input  wire logic [31:0] divisor_i,
	output logic             busy_o,
	output logic             done_o,
	output logic      [6:0]  quot_o
);
	logic [39:0] rem_reg;
	logic [31:0] dvs_reg;
	logic [2:0]  bit_reg;
	logic [39:0] shifted;

	assign shifted = {8'h00, dvs_reg} << bit_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_o  <= 1'b0;
			done_o  <= 1'b0;
			quot_o  <= 7'h00;
			rem_reg <= 40'h0000000000;
			dvs_reg <= 32'h00000000;
			bit_reg <= 3'h0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (!busy_o && start_i) begin
				rem_reg <= dividend_i;
				dvs_reg <= divisor_i;
				bit_reg <= 3'h6;
				quot_o  <= 7'h00;
				// Zero divisor would set every quotient bit
				busy_o  <= (divisor_i != 32'h00000000);
				done_o  <= (divisor_i == 32'h00000000);
			end else if (busy_o) begin
				if (rem_reg >= shifted) begin
					rem_reg         <= rem_reg - shifted;
					quot_o[bit_reg] <= 1'b1;
				end
				if (bit_reg == 3'h0) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end else begin
					bit_reg <= bit_reg - 3'h1;
				end
			end
		end
	end
endmodule : srh_pct_div

// File: srh_pkg.sv
/*
 * Types shared by the state range histogram engine.
 * Assumes srh_regs.svh supplies all numeric constants.
 */
package srh_pkg;
	typedef enum logic [1:0] {SRH_IDLE, SRH_GAP, SRH_SAMPLE} srh_state_type;
	typedef logic [31:0] srh_word_type;
	typedef logic [2:0]  srh_index_type;
endpackage : srh_pkg

// File: srh_regs.svh
/*
 * Register map, field positions, reset values and counts for the state range histogram engine.
 * Assumes a byte-addressed 8-bit Wishbone address; each register is one aligned 32-bit word.
 */
// Functional notes
// RULE_01: A sample is exactly 1024 qualified states, then sorted into the histogram.
// RULE_02: A random delay separates consecutive samples.
// RULE_03: Sampling repeats continuously after start until a stop request arrives.
// RULE_04: First stop request: finish one more full sample, add it, then end.
// RULE_05: Second stop request: abandon the sample in progress, never add it.
// RULE_06: Ranges compare against one label chosen from eight configured bit groupings.
// RULE_07: Each range has programmable minimum and maximum, any label value.
// RULE_08: States mode: each access after an opcode fetch counts by its own value.
// RULE_09: Program activity mode: accesses credit the range of the preceding opcode fetch.
// RULE_10: A running total of sampled states is readable at any moment.
// RULE_11: A setting picks the percentage denominator: all states or in-range states.
// RULE_12: Each range reports its hit count as a percentage of that denominator.
// RULE_13: A state is in range when minimum <= value <= maximum.
`ifndef SRH_REGS_SVH
`define SRH_REGS_SVH

`define SRH_ADR_CTRL       8'h00
`define SRH_ADR_STATUS     8'h04
`define SRH_ADR_TOTAL      8'h08
`define SRH_ADR_INRANGE    8'h0C
`define SRH_ADR_RANGE_EN   8'h10

// Address bits 7:5 select a bank of eight words, indexed by bits 4:2
`define SRH_BANK_MISC      3'h0
`define SRH_BANK_SHIFT     3'h1
`define SRH_BANK_MASK      3'h2
`define SRH_BANK_MIN       3'h4
`define SRH_BANK_MAX       3'h5
`define SRH_BANK_HITS      3'h6
`define SRH_BANK_PCT       3'h7

`define SRH_CTRL_START     0
`define SRH_CTRL_STOP      1
`define SRH_CTRL_MODE      2
`define SRH_CTRL_INCL      3
`define SRH_CTRL_LBL_LO    4
`define SRH_CTRL_LBL_HI    6

`define SRH_STAT_RUN       0
`define SRH_STAT_STOPPING  1
`define SRH_STAT_ABORTED   2
`define SRH_STAT_DONE      3

`define SRH_RST_RANGE_EN   8'h00
`define SRH_RST_MASK       32'hFFFFFFFF
`define SRH_SAMPLE_LAST    10'h3FF
`define SRH_SAMPLE_STATES  32'h00000400
`define SRH_PCT_SCALE      40'h0000000064
`define SRH_LFSR_SEED      16'hACE1
`define SRH_LFSR_TAPS      16'hB400

`endif

// File: test_srh_engine.sv
/*
 * Self-checking bench for the histogram engine: Wishbone tasks set up, run, stop and read back.
 * Assumes the bus model's four-state loop, measured through label 3 (bits 15:8).
 */
`timescale 1ns/100ps
`include "srh_regs.svh"
module test_srh_engine;
	import srh_pkg::*;
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic         ce_i = 1'b1;
	logic         en = 1'b0;
	logic [7:0]   wb_adr_i = 8'h00;
	logic [31:0]  wb_dat_i = 32'h0;
	logic [3:0]   wb_sel_i = 4'hF;
	logic         wb_we_i = 1'b0;
	logic         wb_cyc_i = 1'b0;
	logic         wb_stb_i = 1'b0;
	srh_word_type wb_dat_o;
	logic         wb_ack_o;
	logic         state_clk_i;
	logic         opcode_fetch_i;
	logic [31:0]  probe_data_i;
	logic         running_o;
	srh_word_type q;
	int           errors = 0;
	int           n_compared = 0;
	logic [7:0]   ra [8] = '{8'h00, 8'h10, 8'h2C, 8'h4C, 8'h80, 8'h08, 8'h14, 8'h60};
	logic [31:0]  re [8] = '{32'h0, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0};
	logic [7:0]   lo [6] = '{8'h10, 8'h81, 8'h80, 8'h83, 8'h00, 8'h00};
	logic [7:0]   hi [6] = '{8'h10, 8'h81, 8'h81, 8'hFF, 8'hFF, 8'h0F};
	logic [31:0]  hs [6] = '{32'h100, 32'h100, 32'h200, 32'h0, 32'h0, 32'h0};
	logic [7:0]   pa [6] = '{8'h19, 8'h19, 8'h32, 8'h00, 8'h00, 8'h00};
	logic [7:0]   pi [6] = '{8'h21, 8'h21, 8'h42, 8'h00, 8'h00, 8'h00};

	srh_engine srh_engine_i (.clk_i, .rst_i, .ce_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
		.wb_stb_i, .wb_dat_o, .wb_ack_o, .state_clk_i, .opcode_fetch_i, .probe_data_i, .running_o);
	srh_bus_model srh_bus_model_i (.clk_i, .rst_i, .en_i(en), .state_clk_o(state_clk_i),
		.opcode_fetch_o(opcode_fetch_i), .probe_data_o(probe_data_i));

	always #12.5 clk_i = ~clk_i;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output srh_word_type r);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_adr_i <= a;
		wb_we_i  <= w;
		wb_dat_i <= d;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		// Read before this edge's updates land: ack and data as sampled here
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		if (n == 20) begin
			errors++;
			$display("BAD %0t: no ack", $time);
		end
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		srh_word_type r;
		wb(a, 1'b1, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		srh_word_type r;
		wb(a, 1'b0, 32'h0, r);
		chk(r, exp);
	endtask : rd

	task automatic wait_idle();
		int n;
		n = 0;
		while (running_o !== 1'b0 && n < 30000) begin
			@(posedge clk_i);
			n++;
		end
		chk({31'h0, running_o}, 32'h0);
	endtask : wait_idle

	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	initial begin
		repeat (60000) @(posedge clk_i);
		errors++;
		close_out();
	end

	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		en <= 1'b1;
		for (int i = 0; i < 8; i++) rd(ra[i], re[i]);
		wr(`SRH_ADR_TOTAL, 32'h1234);
		rd(`SRH_ADR_TOTAL, 32'h0);
		wr(8'h2C, 32'h8);
		wr(8'h4C, 32'hFF);
		for (int i = 0; i < 6; i++) begin
			wr(8'h80 + 8'(4 * i), {24'h0, lo[i]});
			wr(8'hA0 + 8'(4 * i), {24'h0, hi[i]});
		end
		wr(`SRH_ADR_RANGE_EN, 32'h2F);
		rd(8'h84, 32'h81);
		// Stop lands in the first gap, so exactly one sample follows
		wr(`SRH_ADR_CTRL, 32'h31);
		wr(`SRH_ADR_CTRL, 32'h32);
		chk({31'h0, running_o}, 32'h1);
		wait_idle();
		wb(`SRH_ADR_STATUS, 1'b0, 32'h0, q);
		chk({31'h0, q[3]}, 32'h1);
		rd(`SRH_ADR_TOTAL, 32'h400);
		rd(`SRH_ADR_INRANGE, 32'h300);
		for (int i = 0; i < 6; i++) rd(8'hC0 + 8'(4 * i), hs[i]);
		repeat (200) @(posedge clk_i);
		for (int i = 0; i < 6; i++) rd(8'hE0 + 8'(4 * i), {24'h0, pa[i]});
		wr(`SRH_ADR_CTRL, 32'h38);
		repeat (200) @(posedge clk_i);
		for (int i = 0; i < 6; i++) rd(8'hE0 + 8'(4 * i), {24'h0, pi[i]});
		rd(`SRH_ADR_CTRL, 32'h38);
		wr(`SRH_ADR_CTRL, 32'h35);
		repeat (14000) @(posedge clk_i);
		chk({31'h0, running_o}, 32'h1);
		rd(`SRH_ADR_TOTAL, 32'h800);
		wr(`SRH_ADR_CTRL, 32'h36);
		wait_idle();
		rd(`SRH_ADR_TOTAL, 32'hC00);
		rd(8'hC4, 32'h0);
		rd(8'hC8, 32'h0);
		// Fetch context carries across gaps, so all 3072 states credit range 0; the check allows 3 fewer
		wb(8'hC0, 1'b0, 32'h0, q);
		chk({31'h0, q >= 32'hBFD}, 32'h1);
		wr(`SRH_ADR_CTRL, 32'h31);
		// Enable low for longer than a whole sample: no state may advance
		ce_i <= 1'b0;
		repeat (7000) @(posedge clk_i);
		chk({31'h0, running_o}, 32'h1);
		ce_i <= 1'b1;
		rd(`SRH_ADR_TOTAL, 32'h0);
		repeat (3000) @(posedge clk_i);
		wr(`SRH_ADR_CTRL, 32'h32);
		wr(`SRH_ADR_CTRL, 32'h32);
		repeat (5) @(posedge clk_i);
		chk({31'h0, running_o}, 32'h0);
		wb(`SRH_ADR_STATUS, 1'b0, 32'h0, q);
		chk({31'h0, q[2]}, 32'h1);
		rd(`SRH_ADR_TOTAL, 32'h0);
		rd(8'hC0, 32'h0);
		wr(`SRH_ADR_CTRL, 32'h32);
		repeat (3) @(posedge clk_i);
		chk({31'h0, running_o}, 32'h0);
		close_out();
	end
endmodule : test_srh_engine
